// ---- inc/ptt_pkg.sv ----
`default_nettype none
package ptt_pkg;
   // bank shape
   localparam int unsigned NUM_CH   = 5;
   localparam int unsigned SYS_CH   = 4;
   localparam int unsigned WAKE_CH  = 4;
   localparam int unsigned CNT_W    = 32;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned STAT_W   = 6;
   localparam int unsigned WAKE_BIT = 5;

   // global register offsets
   localparam logic [7:0] OFS_MCR    = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK   = 8'h08;
   localparam logic [7:0] OFS_STATE  = 8'h0C;

   // channel windows: upper nibble 1..5 selects channel 0..4, lower nibble the register
   localparam logic [3:0] CH_WIN_FIRST = 4'h1;
   localparam logic [3:0] CH_WIN_LAST  = 4'h5;
   localparam logic [3:0] CH_OFS_LOAD  = 4'h0;
   localparam logic [3:0] CH_OFS_CUR   = 4'h4;
   localparam logic [3:0] CH_OFS_CTL   = 4'h8;

   // field positions
   localparam int unsigned MCR_SYS_OFF = 0;
   localparam int unsigned MCR_WAKE_EN = 1;
   localparam int unsigned CTL_RUN     = 0;
   localparam int unsigned CTL_TRIG    = 1;
   localparam int unsigned ST_STOP     = 0;
   localparam int unsigned ST_WAKE_REQ = 1;

   // reset values
   localparam logic [1:0]       MCR_RST  = 2'h0;
   localparam logic [1:0]       CTL_RST  = 2'h0;
   localparam logic [CNT_W-1:0] LOAD_RST = 32'h0000_0000;
   localparam logic [STAT_W-1:0] MASK_RST = 6'h00;
endpackage : ptt_pkg
`default_nettype wire

// ---- hw/ptt_sync.sv ----
`default_nettype none
module ptt_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : ptt_sync
`default_nettype wire

// ---- hw/ptt_channel.sv ----
`default_nettype none
module ptt_channel #(
   parameter int unsigned CNT_W = 32
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             tick_en,
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] load_val,
   output logic      [CNT_W-1:0] count,
   output logic                  expire
);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic             run_q;
   logic             expire_q;
   logic             expire_d;
   logic             start;
   logic             at_zero;

   if (CNT_W < 2 || CNT_W > 32) begin : g_chk
      $error("ptt_channel: CNT_W must be 2..32");
   end

   assign start   = run & ~run_q;
   assign at_zero = (count_q == '0);

   always_comb begin
      count_d  = count_q;
      expire_d = 1'b0;
      if (start) begin
         count_d = load_val;
      end else if (run && tick_en) begin
         if (at_zero) begin
            count_d  = load_val;
            expire_d = 1'b1;
         end else begin
            count_d = count_q - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q  <= '0;
         run_q    <= 1'b0;
         expire_q <= 1'b0;
      end else begin
         count_q  <= count_d;
         run_q    <= run;
         expire_q <= expire_d;
      end
   end

   assign count  = count_q;
   assign expire = expire_q;
endmodule : ptt_channel
`default_nettype wire

// ---- hw/ptt_timer_bank.sv ----
// The address-and-strobe port and the placing of the registers were left to the implementer.
`default_nettype none
module ptt_timer_bank #(
   parameter int unsigned NUM_CH = ptt_pkg::NUM_CH,
   parameter int unsigned CNT_W  = ptt_pkg::CNT_W
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic [ptt_pkg::ADDR_W-1:0]  addr,
   input  wire logic [ptt_pkg::DATA_W-1:0]  wr_data,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [ptt_pkg::DATA_W-1:0]  rd_data,
   input  wire logic                        xtal_clk,
   input  wire logic                        stop_req,
   output logic                             irq,
   output logic      [NUM_CH-1:0]           trig,
   output logic                             wake_restart
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   // the map reserves exactly five channel windows, last one is crystal-clocked
   if (NUM_CH != ptt_pkg::NUM_CH) begin : g_chk_ch
      $error("ptt_timer_bank: NUM_CH must equal the five mapped channels");
   end
   if (CNT_W != ptt_pkg::CNT_W) begin : g_chk_w
      $error("ptt_timer_bank: CNT_W must be 32 to fit the register word");
   end

   // one wake channel, the rest on the system clock
   if (ptt_pkg::WAKE_CH >= NUM_CH || ptt_pkg::SYS_CH + 1 != NUM_CH) begin : g_chk_wake
      $error("ptt_timer_bank: wake channel must be the one past the system channels");
   end

   // status word is one flag per channel plus the wake flag on top
   if (ptt_pkg::STAT_W != NUM_CH + 1 || ptt_pkg::WAKE_BIT != NUM_CH) begin : g_chk_stat
      $error("ptt_timer_bank: status layout does not match the channel count");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [1:0]                  mcr_q;
   logic [1:0]                  mcr_d;
   logic [ptt_pkg::STAT_W-1:0]  status_q;
   logic [ptt_pkg::STAT_W-1:0]  status_d;
   logic [ptt_pkg::STAT_W-1:0]  mask_q;
   logic [ptt_pkg::STAT_W-1:0]  mask_d;
   logic [CNT_W-1:0]            load_q [NUM_CH];
   logic [1:0]                  ctl_q  [NUM_CH];
   logic [CNT_W-1:0]            cur    [NUM_CH];
   logic [NUM_CH-1:0]           expire;
   logic [NUM_CH-1:0]           tick_en;
   logic [NUM_CH-1:0]           run_vec;
   logic [NUM_CH-1:0]           trig_en_vec;
   logic [NUM_CH-1:0]           ld_sel;
   logic [NUM_CH-1:0]           ctl_sel;
   logic [NUM_CH-1:0]           trig_q;
   logic [ptt_pkg::DATA_W-1:0]  rd_data_q;
   logic [ptt_pkg::DATA_W-1:0]  rd_mux;
   logic                        irq_q;
   logic                        wake_q;
   logic                        wake_d;
   logic                        stop_q;
   logic                        xtal_s;
   logic                        xtal_prev_q;
   logic                        xtal_tick;
   logic                        sys_tick;
   logic                        wake_evt;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   logic [3:0]  win;
   logic [3:0]  sub;
   logic        ch_hit;
   logic [3:0]  ch_idx4;
   logic [2:0]  ch_idx;
   logic        hit_mcr;
   logic        hit_status;
   logic        hit_mask;
   logic        hit_state;
   logic        hit_load;
   logic        hit_cur;
   logic        hit_ctl;
   logic        wr_mcr;
   logic        wr_status;
   logic        wr_mask;
   logic        wr_load;
   logic        wr_ctl;

   assign win        = addr[7:4];
   assign sub        = addr[3:0];
   assign ch_hit     = (win >= ptt_pkg::CH_WIN_FIRST) && (win <= ptt_pkg::CH_WIN_LAST);
   assign ch_idx4    = win - ptt_pkg::CH_WIN_FIRST;
   assign ch_idx     = ch_idx4[2:0];
   assign hit_mcr    = (addr == ptt_pkg::OFS_MCR);
   assign hit_status = (addr == ptt_pkg::OFS_STATUS);
   assign hit_mask   = (addr == ptt_pkg::OFS_MASK);
   assign hit_state  = (addr == ptt_pkg::OFS_STATE);
   assign hit_load   = ch_hit && (sub == ptt_pkg::CH_OFS_LOAD);
   assign hit_cur    = ch_hit && (sub == ptt_pkg::CH_OFS_CUR);
   assign hit_ctl    = ch_hit && (sub == ptt_pkg::CH_OFS_CTL);
   assign wr_mcr     = wr_en && hit_mcr;
   assign wr_status  = wr_en && hit_status;
   assign wr_mask    = wr_en && hit_mask;
   assign wr_load    = wr_en && hit_load;
   assign wr_ctl     = wr_en && hit_ctl;

   ////////////////////////////////////////////////////////////////////////////
   // crystal clock as a sampled level; its rising edge becomes a one-cycle tick

   ptt_sync #(
      .WIDTH    (1)
   ) u_xtal_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (xtal_clk),
      .sync_out (xtal_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         xtal_prev_q <= 1'b0;
      end else begin
         xtal_prev_q <= xtal_s;
      end
   end

   // crystal must be well below clk/2 or edges are missed
   // a crystal already high at reset release gives one early tick
   assign xtal_tick = xtal_s & ~xtal_prev_q;

   // in stop mode the system-clocked channels see no tick at all
   assign sys_tick  = ~stop_q & ~mcr_q[ptt_pkg::MCR_SYS_OFF];

   ////////////////////////////////////////////////////////////////////////////
   // channels

   genvar gi;
   for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign run_vec[gi]     = ctl_q[gi][ptt_pkg::CTL_RUN];
      assign trig_en_vec[gi] = ctl_q[gi][ptt_pkg::CTL_TRIG];

      // the crystal channel sees only the synchronised crystal edge
      if (gi == ptt_pkg::WAKE_CH) begin : g_wake
         assign tick_en[gi] = xtal_tick;
      end else begin : g_sys
         assign tick_en[gi] = sys_tick;
      end

      ptt_channel #(
         .CNT_W    (CNT_W)
      ) u_ch (
         .clk      (clk),
         .rst      (rst),
         .tick_en  (tick_en[gi]),
         .run      (run_vec[gi]),
         .load_val (load_q[gi]),
         .count    (cur[gi]),
         .expire   (expire[gi])
      );

      // channel index means something only inside a channel window
      assign ld_sel[gi]  = wr_load && (ch_idx == 3'(gi));
      assign ctl_sel[gi] = wr_ctl && (ch_idx == 3'(gi));

      // a new load value is picked up at the next reload, not mid-period
      always_ff @(posedge clk) begin
         if (rst) begin
            load_q[gi] <= ptt_pkg::LOAD_RST;
         end else if (ld_sel[gi]) begin
            load_q[gi] <= wr_data[CNT_W-1:0];
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            ctl_q[gi] <= ptt_pkg::CTL_RST;
         end else if (ctl_sel[gi]) begin
            ctl_q[gi] <= wr_data[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // wake-up request: set on wake-channel expiry during stop, dropped on exit

   // without the wake enable the channel still counts and flags, but never restarts
   assign wake_evt = expire[ptt_pkg::WAKE_CH] & stop_q & mcr_q[ptt_pkg::MCR_WAKE_EN];

   always_comb begin
      wake_d = wake_q;
      if (wake_evt) begin
         wake_d = 1'b1;
      end else if (!stop_q) begin
         wake_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // global registers; a new event wins over a write-one clear

   assign mcr_d  = wr_mcr ? wr_data[1:0] : mcr_q;
   assign mask_d = wr_mask ? wr_data[ptt_pkg::STAT_W-1:0] : mask_q;

   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = status_q & ~wr_data[ptt_pkg::STAT_W-1:0];
      end
      status_d[NUM_CH-1:0]       = status_d[NUM_CH-1:0] | expire;
      status_d[ptt_pkg::WAKE_BIT] = status_d[ptt_pkg::WAKE_BIT] | wake_evt;
   end

   // control bits take effect on the edge after the write
   always_ff @(posedge clk) begin
      if (rst) begin
         mcr_q <= ptt_pkg::MCR_RST;
      end else begin
         mcr_q <= mcr_d;
      end
   end

   // a mask change reaches irq one edge later
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= ptt_pkg::MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   // stop level comes from the same clock domain, so one register suffices
   always_ff @(posedge clk) begin
      if (rst) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= stop_req;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal outputs: interrupt level and conversion-queue trigger pulses

   // irq looks at the next status so a clear drops it on the same edge
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_d & mask_q);
      end
   end

   // trig is one cycle long; the queue unit must sample every clock
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_q <= '0;
      end else begin
         trig_q <= expire & trig_en_vec;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path; unmapped addresses return zero

   logic [ptt_pkg::DATA_W-1:0] ch_rd;
   logic [ptt_pkg::DATA_W-1:0] glb_rd;
   logic [ptt_pkg::DATA_W-1:0] state_word;

   assign state_word = {{(ptt_pkg::DATA_W-2){1'b0}}, wake_q, stop_q};

   always_comb begin
      ch_rd = '0;
      if (ch_hit) begin
         if (sub == ptt_pkg::CH_OFS_LOAD) begin
            ch_rd = load_q[ch_idx];
         end else if (sub == ptt_pkg::CH_OFS_CUR) begin
            ch_rd = cur[ch_idx];
         end else if (sub == ptt_pkg::CH_OFS_CTL) begin
            ch_rd = {{(ptt_pkg::DATA_W-2){1'b0}}, ctl_q[ch_idx]};
         end
      end
   end

   always_comb begin
      glb_rd = '0;
      if (hit_mcr) begin
         glb_rd = {{(ptt_pkg::DATA_W-2){1'b0}}, mcr_q};
      end else if (hit_status) begin
         glb_rd = {{(ptt_pkg::DATA_W-ptt_pkg::STAT_W){1'b0}}, status_q};
      end else if (hit_mask) begin
         glb_rd = {{(ptt_pkg::DATA_W-ptt_pkg::STAT_W){1'b0}}, mask_q};
      end else if (hit_state) begin
         glb_rd = state_word;
      end
   end

   assign rd_mux = ch_rd | glb_rd;

   // data stand only in the cycle after the strobe
   // zero outside the answer cycle lets reads be or-combined upstream
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= rd_en ? rd_mux : '0;
      end
   end

   assign rd_data      = rd_data_q;
   assign irq          = irq_q;
   assign trig         = trig_q;
   assign wake_restart = wake_q;

endmodule : ptt_timer_bank
`default_nettype wire

// ---- sim/ptt_timer_bank_assertions.sv ----
`default_nettype none
module ptt_checker #(
   parameter int unsigned NUM_CH = 5,
   parameter int unsigned CNT_W  = 32
) (
   input wire logic                       clk,
   input wire logic                       rst,
   input wire logic [ptt_pkg::ADDR_W-1:0] addr,
   input wire logic [ptt_pkg::DATA_W-1:0] wr_data,
   input wire logic                       wr_en,
   input wire logic                       rd_en,
   input wire logic [ptt_pkg::DATA_W-1:0] rd_data,
   input wire logic                       xtal_clk,
   input wire logic                       stop_req,
   input wire logic                       irq,
   input wire logic [NUM_CH-1:0]          trig,
   input wire logic                       wake_restart
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!rd_en |=> rd_data == '0)
      else $error("read data without a read");
   rd_unmapped_a: assert property (rd_en && addr == 8'hF0 |=> rd_data == '0)
      else $error("unmapped read not zero");
   state_read_a: assert property (rd_en && addr == ptt_pkg::OFS_STATE |=>
      rd_data[1] == $past(wake_restart) && rd_data[31:2] == '0)
      else $error("state read mismatch");
   mask_off_a: assert property (wr_en && addr == ptt_pkg::OFS_MASK && wr_data == '0
      ##1 !(wr_en && addr == ptt_pkg::OFS_MASK) |=> !irq)
      else $error("irq with empty mask");
   // margin covers the registered stop plus the flag pipeline
   stop_freeze_a: assert property (stop_req [*5] |-> trig[3:0] == '0)
      else $error("system channel fired in stop");
   wake_only_stop_a: assert property ($rose(wake_restart) |->
      $past(stop_req) || $past(stop_req, 2))
      else $error("restart outside stop");
   wake_clear_a: assert property (!stop_req [*4] |-> !wake_restart)
      else $error("restart held after stop");
   // xtal edges are at least four clocks apart after the synchroniser
   wake_tick_a: assert property (trig[4] |=> !trig[4] [*3])
      else $error("wake channel faster than crystal");
   ////////////////////////////////////////////////////////////////////////////
   cover property (trig[1]);
   cover property ($rose(wake_restart));
   cover property (irq);
endmodule : ptt_checker
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                        clk = 1'b0;
   logic                        rst = 1'b1;
   logic [7:0]                  addr = 8'h00;
   logic [31:0]                 wr_data = 32'h0000_0000;
   logic                        wr_en = 1'b0;
   logic                        rd_en = 1'b0;
   logic [31:0]                 rd_data;
   logic                        xtal_clk = 1'b0;
   logic                        stop_req = 1'b0;
   logic                        irq;
   logic [ptt_pkg::NUM_CH-1:0]  trig;
   logic                        wake_restart;
   int                          mismatches = 0;
   int                          checked = 0;
   int                          n;
   logic [31:0]                 v;
   logic [31:0]                 w;

   always #5 clk = ~clk;
   // 83 ns half period puts every fifth crystal edge on a clock edge
   always #83 xtal_clk = ~xtal_clk;

   ptt_timer_bank dut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .xtal_clk(xtal_clk), .stop_req(stop_req),
      .irq(irq), .trig(trig), .wake_restart(wake_restart));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   // two reads of channel 0 count, five clocks apart
   task automatic cur_step(input logic [31:0] d);
      rd(8'h14, v);
      tick(3);
      rd(8'h14, w);
      check(w, v - d);
   endtask : cur_step

   task automatic finish_test;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 96; a += 4) begin
         rd(8'(a), v);
         check(v, 32'h0000_0000);
      end
      for (int c = 0; c < 5; c++) wr(8'(16 * c + 16), 32'(c + 2));
      for (int c = 0; c < 5; c++) begin
         rd(8'(16 * c + 16), v);
         check(v, 32'(c + 2));
      end
      wr(8'h14, 32'h1234_5678);
      wr(8'hF0, 32'h1234_5678);
      rd(8'h14, v);
      check(v, 32'h0000_0000);
      rd(8'hF0, v);
      check(v, 32'h0000_0000);
      // channel 1 with trigger: period is load plus one
      wr(8'h20, 32'h0000_0003);
      wr(8'h28, 32'h0000_0003);
      n = 0;
      while (trig[1] !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      check(32'(trig[1]), 32'h0000_0001);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (trig[1] !== 1'b1 && n < 20);
      check(32'(n), 32'h0000_0004);
      wr(8'h28, 32'h0000_0000);
      rd(ptt_pkg::OFS_STATUS, v);
      check(v, 32'h0000_0002);
      wr(ptt_pkg::OFS_MASK, 32'h0000_0000);
      tick(2);
      check(32'(irq), 32'h0000_0000);
      wr(ptt_pkg::OFS_MASK, 32'h0000_0002);
      tick(2);
      check(32'(irq), 32'h0000_0001);
      wr(ptt_pkg::OFS_STATUS, 32'h0000_0002);
      rd(ptt_pkg::OFS_STATUS, v);
      check(v, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      // channel 2 flags without trigger
      wr(8'h30, 32'h0000_0001);
      wr(8'h38, 32'h0000_0001);
      w = 32'h0000_0000;
      repeat (12) begin
         tick(1);
         if (trig[2] !== 1'b0) w = 32'h0000_0001;
      end
      check(w, 32'h0000_0000);
      wr(8'h38, 32'h0000_0000);
      rd(ptt_pkg::OFS_STATUS, v);
      check(v, 32'h0000_0004);
      wr(ptt_pkg::OFS_STATUS, 32'h0000_0004);
      // stop mode with the crystal wake channel
      wr(8'h10, 32'h0000_FFFF);
      wr(8'h18, 32'h0000_0001);
      wr(ptt_pkg::OFS_MCR, 32'h0000_0002);
      wr(8'h50, 32'h0000_0002);
      wr(8'h58, 32'h0000_0003);
      cur_step(32'h0000_0005);
      @(posedge clk);
      stop_req <= 1'b1;
      tick(3);
      cur_step(32'h0000_0000);
      n = 0;
      w = 32'h0000_0000;
      while (wake_restart !== 1'b1 && n < 300) begin
         tick(1);
         n++;
         if (trig[4] === 1'b1) w = 32'h0000_0001;
      end
      check(w, 32'h0000_0001);
      check(32'(wake_restart), 32'h0000_0001);
      rd(ptt_pkg::OFS_STATE, v);
      check(v, 32'h0000_0003);
      rd(ptt_pkg::OFS_STATUS, v);
      check(v, 32'h0000_0030);
      @(posedge clk);
      stop_req <= 1'b0;
      tick(4);
      check(32'(wake_restart), 32'h0000_0000);
      cur_step(32'h0000_0005);
      wr(ptt_pkg::OFS_MCR, 32'h0000_0001);
      cur_step(32'h0000_0000);
      finish_test();
   end
endmodule : tb_top

bind ptt_timer_bank ptt_checker #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) chk (.clk(clk), .rst(rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
   .xtal_clk(xtal_clk), .stop_req(stop_req), .irq(irq), .trig(trig),
   .wake_restart(wake_restart));
`default_nettype wire
